// ---- inc/rtc_alarm_params.svh ----
// offsets, field positions, reset values and timing constants for the alarm and countdown block
// Summary of operation
// R1: five alarm target bytes sit at 0x0b to 0x0f: second, minute, hour, day, weekday.
// R2: bit 7 of each target disables its field when 1; reset value is 1.
// R3: second and minute targets are BCD, tens in bits 6:4, units in 3:0.
// R4: hour target: 12h uses bit 5 afternoon, bit 4 tens; 24h uses bits 5:4 tens.
// R5: hour target layout follows the hour format bit of the first control register.
// R6: day target is BCD, tens in bits 5:4, units 3:0, bit 6 reads 0.
// R7: weekday target holds 0 to 6 in bits 2:0, bits 6:3 read 0.
// R8: each enabled field is compared with its matching current time counter.
// R9: when all enabled comparisons first match, the alarm flag is set.
// R10: alarm flag stays set until software clears it; hardware never clears it.
// R11: after clearing, only a new transition into a match sets the flag again.
// R12: with alarm interrupt enable set, the interrupt pin follows the alarm flag.
// R13: countdown value is 8-bit binary 0x00 to 0xff, reset value 0x00.
// R14: countdown period is T divided by the selected source clock frequency.
// R15: mode bits 4:3 pick 4096 Hz, 64 Hz, 1 Hz or 1/60 Hz; reset 11.
// R16: mode bit 2 runs countdown, bit 1 enables its interrupt, bits 7:5 read 0.
// R17: mode bit 0 at 0 makes the interrupt pin follow the countdown flag.
// R18: mode bit 0 at 1 makes each countdown expiry a pulse on the pin.
// R19: decrementing from 1 sets the countdown flag, reloads T and starts again.
// R20: loading T of 0 stops the timer; 1 to 255 are valid lengths.
// R21: countdown flag is cleared only by software, never by hardware.
// R22: alarm match is evaluated on each one-second update after counters settle.
// R23: interrupt pin asserts while either enabled source requests it.
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH

`define SEC_TGT_ADDR      8'h0b
`define MIN_TGT_ADDR      8'h0c
`define HOUR_TGT_ADDR     8'h0d
`define DAY_TGT_ADDR      8'h0e
`define WDAY_TGT_ADDR     8'h0f
`define CD_VALUE_ADDR     8'h10
`define CD_CTRL_ADDR      8'h11

`define FIELD_DIS_BIT     7
`define AFTERNOON_BIT     5

`define SEC_TGT_MASK      8'hff
`define HOUR_TGT_MASK     8'hbf
`define DAY_TGT_MASK      8'hbf
`define WDAY_TGT_MASK     8'h87
`define CD_CTRL_MASK      8'h1f

`define TGT_RESET         8'h80
`define CD_VALUE_RESET    8'h00
`define CD_CTRL_RESET     8'h18

`define CD_SRC_LSB        3
`define CD_RUN_BIT        2
`define CD_IRQ_EN_BIT     1
`define CD_PULSE_BIT      0

`define CD_RELOAD_COUNT   8'h01

`endif

// ---- inc/rtc_alarm_pkg.sv ----
// types shared by the alarm compare and countdown block
package rtc_alarm_pkg;

  typedef enum logic [1:0] {
    SRC_4096HZ  = 2'b00,
    SRC_64HZ    = 2'b01,
    SRC_1HZ     = 2'b10,
    SRC_1_60HZ  = 2'b11
  } countdown_src_type;

  typedef struct packed {
    logic [7:0] count;
    logic       run_prev;
    logic       expire;
  } countdown_state_type;

  typedef struct packed {
    logic [7:0] sec_tgt;
    logic [7:0] min_tgt;
    logic [7:0] hour_tgt;
    logic [7:0] day_tgt;
    logic [7:0] wday_tgt;
    logic [7:0] cd_value;
    logic [7:0] cd_ctrl;
    logic       match_prev;
    logic       alarm_flag;
    logic       countdown_flag;
    logic       pulse_active;
    logic       int_n;
    logic [7:0] rd_data;
  } alarm_state_type;

endpackage : rtc_alarm_pkg

// ---- src/countdown_core.sv ----
// countdown counter: loads, decrements on source ticks and reloads on expiry
`include "rtc_alarm_params.svh"

module countdown_core (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       src_tick_i,
  input  wire logic       run_i,
  input  wire logic [7:0] value_i,
  input  wire logic       load_i,
  output logic      [7:0] count_o,
  output logic            expire_o
);
  import rtc_alarm_pkg::*;

  countdown_state_type s_r;
  countdown_state_type s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.expire   = 1'b0;
    s_nxt.run_prev = run_i;
    if (load_i) begin
      // a new value takes effect at once
      s_nxt.count = value_i;
    end else if (run_i && !s_r.run_prev) begin
      s_nxt.count = value_i;
    end else if (run_i && (value_i != 8'h00) && src_tick_i) begin  // [R20] [R14]
      if (s_r.count == `CD_RELOAD_COUNT) begin
        s_nxt.count  = value_i;                                       // [R19]
        s_nxt.expire = 1'b1;                                          // [R19]
      end else if (s_r.count == 8'h00) begin
        s_nxt.count = value_i;
      end else begin
        s_nxt.count = s_r.count - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_r <= '{count: `CD_VALUE_RESET, run_prev: 1'b0, expire: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_o  = s_r.count;
  assign expire_o = s_r.expire;

endmodule : countdown_core

// ---- src/rtc_alarm_compare_and_countdown_ctrl.sv ----
// alarm target registers, alarm comparison, countdown control and interrupt pin
`include "rtc_alarm_params.svh"

module rtc_alarm_compare_and_countdown_ctrl (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // register port from the serial slave
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wr_data_i,
  output logic      [7:0] reg_rd_data_o,
  // current time from the timekeeping counters
  input  wire logic       time_update_i,
  input  wire logic [7:0] cur_second_i,
  input  wire logic [7:0] cur_minute_i,
  input  wire logic [7:0] cur_hour_i,
  input  wire logic [7:0] cur_day_i,
  input  wire logic [7:0] cur_weekday_i,
  input  wire logic       hour_format_12h_i,
  // control bits held in the control registers
  input  wire logic       alarm_irq_enable_i,
  input  wire logic       alarm_flag_clr_i,
  input  wire logic       countdown_flag_clr_i,
  // source ticks from the oscillator divider chain
  input  wire logic       tick_4096hz_i,
  input  wire logic       tick_64hz_i,
  input  wire logic       tick_1hz_i,
  input  wire logic       tick_1_60hz_i,
  // status and pin
  output logic            alarm_flag_o,
  output logic            countdown_flag_o,
  output logic            irq_n_o
);
  import rtc_alarm_pkg::*;

  alarm_state_type   s_r;
  alarm_state_type   s_nxt;

  logic [7:0]        cd_count;
  logic              cd_expire;
  logic              cd_load;
  logic [7:0]        cd_value_nxt;
  logic              cd_src_tick;
  logic              pulse_end_tick;
  logic              all_match;
  logic              any_enabled;
  countdown_src_type cd_src;

  // field comparison: a disabled field always agrees
  function automatic logic field_match(
    input logic       disable_bit,
    input logic [7:0] target,
    input logic [7:0] current,
    input logic [7:0] mask
  );
    field_match = disable_bit || ((target & mask) == (current & mask));
  endfunction : field_match

  // hour layout as a normalised key: {afternoon, tens[1:0], units}
  function automatic logic [6:0] hour_key(
    input logic       is_12h,
    input logic [7:0] hour
  );
    if (is_12h) begin
      hour_key = {hour[`AFTERNOON_BIT], 1'b0, hour[4], hour[3:0]};
    end else begin
      hour_key = {1'b0, hour[5:4], hour[3:0]};
    end
  endfunction : hour_key

  // read value of a register at an address
  function automatic logic [7:0] reg_read(
    input alarm_state_type st,
    input logic [7:0]      addr,
    input logic [7:0]      count
  );
    case (addr)
      `SEC_TGT_ADDR:  reg_read = st.sec_tgt;
      `MIN_TGT_ADDR:  reg_read = st.min_tgt;
      `HOUR_TGT_ADDR: reg_read = st.hour_tgt;
      `DAY_TGT_ADDR:  reg_read = st.day_tgt;
      `WDAY_TGT_ADDR: reg_read = st.wday_tgt;
      `CD_VALUE_ADDR: reg_read = count;
      `CD_CTRL_ADDR:  reg_read = st.cd_ctrl;
      default:        reg_read = 8'h00;
    endcase
  endfunction : reg_read

  assign cd_src  = countdown_src_type'(s_r.cd_ctrl[`CD_SRC_LSB +: 2]);
  assign cd_load = reg_wr_i && (reg_addr_i == `CD_VALUE_ADDR);
  // the counter loads in the write cycle, so it must see the byte being written, not the old value
  assign cd_value_nxt = cd_load ? reg_wr_data_i : s_r.cd_value;

  // source clock choice and end of an interrupt pulse
  always_comb begin
    case (cd_src)                                                     // [R15]
      SRC_4096HZ: begin
        cd_src_tick    = tick_4096hz_i;
        pulse_end_tick = tick_4096hz_i;
      end
      SRC_64HZ: begin
        cd_src_tick    = tick_64hz_i;
        pulse_end_tick = tick_64hz_i;
      end
      SRC_1HZ: begin
        cd_src_tick    = tick_1hz_i;
        pulse_end_tick = tick_64hz_i;
      end
      SRC_1_60HZ: begin
        cd_src_tick    = tick_1_60hz_i;
        pulse_end_tick = tick_64hz_i;
      end
      default: begin
        cd_src_tick    = 1'b0;
        pulse_end_tick = 1'b0;
      end
    endcase
  end

  countdown_core u_countdown (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .src_tick_i (cd_src_tick),
    .run_i      (s_r.cd_ctrl[`CD_RUN_BIT]),                           // [R16]
    .value_i    (cd_value_nxt),
    .load_i     (cd_load),
    .count_o    (cd_count),
    .expire_o   (cd_expire)
  );

  // comparison of every enabled field against the running time
  always_comb begin
    all_match = field_match(s_r.sec_tgt[`FIELD_DIS_BIT], s_r.sec_tgt, cur_second_i, 8'h7f)       // [R8] [R2]
             && field_match(s_r.min_tgt[`FIELD_DIS_BIT], s_r.min_tgt, cur_minute_i, 8'h7f)      // [R8]
             && field_match(s_r.hour_tgt[`FIELD_DIS_BIT],
                            {1'b0, hour_key(hour_format_12h_i, s_r.hour_tgt)},                  // [R5] [R4]
                            {1'b0, hour_key(hour_format_12h_i, cur_hour_i)}, 8'h7f)
             && field_match(s_r.day_tgt[`FIELD_DIS_BIT], s_r.day_tgt, cur_day_i, 8'h3f)         // [R8]
             && field_match(s_r.wday_tgt[`FIELD_DIS_BIT], s_r.wday_tgt, cur_weekday_i, 8'h07);  // [R8]
    any_enabled = !(s_r.sec_tgt[`FIELD_DIS_BIT] && s_r.min_tgt[`FIELD_DIS_BIT]
                    && s_r.hour_tgt[`FIELD_DIS_BIT] && s_r.day_tgt[`FIELD_DIS_BIT]
                    && s_r.wday_tgt[`FIELD_DIS_BIT]);
  end

  always_comb begin
    s_nxt = s_r;

    // register writes, unused bits forced to zero
    if (reg_wr_i) begin
      case (reg_addr_i)                                               // [R1]
        `SEC_TGT_ADDR: begin
          s_nxt.sec_tgt = reg_wr_data_i & `SEC_TGT_MASK;              // [R3]
        end
        `MIN_TGT_ADDR: begin
          s_nxt.min_tgt = reg_wr_data_i & `SEC_TGT_MASK;              // [R3]
        end
        `HOUR_TGT_ADDR: begin
          s_nxt.hour_tgt = reg_wr_data_i & `HOUR_TGT_MASK;            // [R4]
        end
        `DAY_TGT_ADDR: begin
          s_nxt.day_tgt = reg_wr_data_i & `DAY_TGT_MASK;              // [R6]
        end
        `WDAY_TGT_ADDR: begin
          s_nxt.wday_tgt = reg_wr_data_i & `WDAY_TGT_MASK;            // [R7]
        end
        `CD_VALUE_ADDR: begin
          s_nxt.cd_value = reg_wr_data_i;                             // [R13]
        end
        `CD_CTRL_ADDR: begin
          s_nxt.cd_ctrl = reg_wr_data_i & `CD_CTRL_MASK;              // [R16]
        end
        default: begin
          s_nxt.cd_ctrl = s_r.cd_ctrl;
        end
      endcase
    end

    // alarm: sampled once per second update, edge of the match sets the flag
    if (alarm_flag_clr_i) begin
      s_nxt.alarm_flag = 1'b0;                                        // [R10]
    end
    if (time_update_i) begin                                          // [R22]
      s_nxt.match_prev = all_match && any_enabled;
      if (all_match && any_enabled && !s_r.match_prev) begin          // [R11]
        s_nxt.alarm_flag = 1'b1;                                      // [R9]
      end
    end

    // countdown flag: only software clears it, a new expiry wins
    if (countdown_flag_clr_i) begin
      s_nxt.countdown_flag = 1'b0;                                    // [R21]
    end
    if (cd_expire) begin
      s_nxt.countdown_flag = 1'b1;                                    // [R19]
    end

    // pulse mode: a short pulse per expiry, independent of the flag
    if (pulse_end_tick) begin
      s_nxt.pulse_active = 1'b0;
    end
    if (cd_expire) begin
      s_nxt.pulse_active = 1'b1;                                      // [R18]
    end

    // interrupt pin, active low, either source may pull it
    s_nxt.int_n = !((alarm_irq_enable_i && s_nxt.alarm_flag)          // [R12] [R23]
                 || (s_nxt.cd_ctrl[`CD_IRQ_EN_BIT]
                     && (s_nxt.cd_ctrl[`CD_PULSE_BIT] ? s_nxt.pulse_active      // [R18]
                                                      : s_nxt.countdown_flag))); // [R17]

    // registered read data, the countdown address returns the live count
    s_nxt.rd_data = reg_read(s_r, reg_addr_i, cd_count);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_r.sec_tgt        <= `TGT_RESET;                               // [R2]
      s_r.min_tgt        <= `TGT_RESET;
      s_r.hour_tgt       <= `TGT_RESET;
      s_r.day_tgt        <= `TGT_RESET;
      s_r.wday_tgt       <= `TGT_RESET;
      s_r.cd_value       <= `CD_VALUE_RESET;                          // [R13]
      s_r.cd_ctrl        <= `CD_CTRL_RESET;                           // [R15]
      s_r.match_prev     <= 1'b0;
      s_r.alarm_flag     <= 1'b0;
      s_r.countdown_flag <= 1'b0;
      s_r.pulse_active   <= 1'b0;
      s_r.int_n          <= 1'b1;
      s_r.rd_data        <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rd_data_o    = s_r.rd_data;
  assign alarm_flag_o     = s_r.alarm_flag;
  assign countdown_flag_o = s_r.countdown_flag;
  assign irq_n_o          = s_r.int_n;

endmodule : rtc_alarm_compare_and_countdown_ctrl

// ---- tb/rtc_alarm_chk.sv ----
// port checker for the alarm compare and countdown block
module rtc_alarm_chk (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wr_data_i,
  input wire logic [7:0] reg_rd_data_o,
  input wire logic       time_update_i,
  input wire logic       alarm_irq_enable_i,
  input wire logic       alarm_flag_clr_i,
  input wire logic       countdown_flag_clr_i,
  input wire logic       tick_4096hz_i,
  input wire logic       tick_64hz_i,
  input wire logic       tick_1hz_i,
  input wire logic       tick_1_60hz_i,
  input wire logic       alarm_flag_o,
  input wire logic       countdown_flag_o,
  input wire logic       irq_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic any_tick;
  assign any_tick = tick_4096hz_i | tick_64hz_i | tick_1hz_i | tick_1_60hz_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_wr;
    reg_wr_i && (reg_addr_i == 8'h0b || reg_addr_i == 8'h0c);
  endsequence
  sequence s_held;
    !reg_wr_i && $stable(reg_addr_i);
  endsequence
  sequence s_alarm_req;
    alarm_irq_enable_i && alarm_flag_o;
  endsequence
  property p_rd_back;
    s_wr ##1 s_held |=> reg_rd_data_o == $past(reg_wr_data_i, 2);
  endproperty
  property p_unmapped;
    reg_addr_i < 8'h0b || reg_addr_i > 8'h11 |=> reg_rd_data_o == 8'h00;
  endproperty
  property p_wday_bits;
    $past(reg_addr_i) == 8'h0f |-> reg_rd_data_o[6:3] == 4'h0;
  endproperty
  property p_ctrl_bits;
    $past(reg_addr_i) == 8'h11 |-> reg_rd_data_o[7:5] == 3'h0;
  endproperty
  property p_af_hold;
    alarm_flag_o && !alarm_flag_clr_i |=> alarm_flag_o;
  endproperty
  property p_af_clear;
    alarm_flag_o && alarm_flag_clr_i && !time_update_i |=> !alarm_flag_o;
  endproperty
  property p_af_cause;
    $rose(alarm_flag_o) |-> $past(time_update_i);
  endproperty
  property p_cf_hold;
    countdown_flag_o && !countdown_flag_clr_i |=> countdown_flag_o;
  endproperty
  property p_cf_cause;
    $rose(countdown_flag_o) |-> $past(any_tick, 2);
  endproperty
  property p_irq_alarm;
    s_alarm_req ##1 s_alarm_req |-> !irq_n_o;
  endproperty
  property p_reset_out;
    $fell(reset_i) |-> !alarm_flag_o && !countdown_flag_o && irq_n_o;
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("read back differs");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_wday_bits: assert property (p_wday_bits) else $error("weekday bits");
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits");
  a_af_hold: assert property (p_af_hold) else $error("alarm flag lost");
  a_af_clear: assert property (p_af_clear) else $error("alarm flag kept");
  a_af_cause: assert property (p_af_cause) else $error("alarm flag cause");
  a_cf_hold: assert property (p_cf_hold) else $error("count flag lost");
  a_cf_cause: assert property (p_cf_cause) else $error("count flag cause");
  a_irq_alarm: assert property (p_irq_alarm) else $error("pin not low");
  a_reset_out: assert property (p_reset_out) else $error("reset outputs");
endmodule : rtc_alarm_chk

bind rtc_alarm_compare_and_countdown_ctrl rtc_alarm_chk u_chk (.*);

// ---- tb/tb_top.sv ----
// self-checking bench for the alarm compare and countdown block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, wr, upd, h12, alarm_irq_enable, aclr, cclr, af, cf, irq_n, m, prv, eaf;
  logic [7:0] addr, wdat, rdat, sec, mnt, hr, day, wd;
  logic [3:0] tk;
  logic [7:0] rv [7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h18};
  logic [7:0] mk [7] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'hff, 8'h1f};
  int         fail_count, comparisons, seed, i, j, n;
  tick_gen u_tick (.sys_clk_i(clk), .reset_i(rst), .tick_o(tk));
  rtc_alarm_compare_and_countdown_ctrl dut (
    .sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wr_data_i(wdat), .reg_rd_data_o(rdat), .time_update_i(upd),
    .cur_second_i(sec), .cur_minute_i(mnt), .cur_hour_i(hr), .cur_day_i(day),
    .cur_weekday_i(wd), .hour_format_12h_i(h12), .alarm_irq_enable_i(alarm_irq_enable),
    .alarm_flag_clr_i(aclr), .countdown_flag_clr_i(cclr), .tick_4096hz_i(tk[0]),
    .tick_64hz_i(tk[1]), .tick_1hz_i(tk[2]), .tick_1_60hz_i(tk[3]),
    .alarm_flag_o(af), .countdown_flag_o(cf), .irq_n_o(irq_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk(rdat, e);
  endtask : rreg
  task automatic clrf;
    @(posedge clk);
    {aclr, cclr} <= 2'b11;
    @(posedge clk);
    {aclr, cclr} <= 2'b00;
    eaf = 1'b0;
    #1;
  endtask : clrf
  task automatic wait_cf(input int s, output int c);
    int k;
    c = 0;
    for (k = 0; k < 1000 && cf !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (tk[s] === 1'b1)
        c++;
    end
    if (k == 1000) begin
      fail_count++;
      final_report();
    end
  endtask : wait_cf
  initial begin
    seed = 89929;
    {rst, wr, upd, h12, alarm_irq_enable, aclr, cclr} = 7'h40;
    {addr, wdat, sec, mnt, hr, day, wd} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++)
      rreg(8'(11 + i), rv[i]);
    for (i = 0; i < 7; i++) begin
      n = $random(seed);
      wreg(8'(11 + i), n[7:0]);
      rv[i] = n[7:0] & mk[i];
      rreg(8'(11 + i), rv[i]);
    end
    wreg(8'h12, 8'hff);
    rreg(8'h12, 8'h00);
    $display("register test done");
    wreg(8'h11, 8'h00);
    for (i = 0; i < 5; i++)
      wreg(8'(11 + i), i == 0 ? 8'h25 : i == 2 ? 8'h12 : 8'h80);
    clrf();
    prv = 1'b0;
    for (i = 0; i < 40; i++) begin
      n = $random(seed);
      @(posedge clk);
      sec <= n[0] ? 8'h25 : 8'h24;
      hr <= n[1] ? 8'h12 : 8'h11;
      {mnt, day, wd} <= n[31:8];
      h12 <= n[2];
      alarm_irq_enable <= n[3];
      aclr <= n[4];
      upd <= 1'b1;
      m = n[0] && n[1];
      eaf = (m && !prv) || (eaf && !n[4]);
      prv = m;
      @(posedge clk);
      {upd, aclr} <= 2'b00;
      @(posedge clk);
      #1;
      chk(af, eaf);
      chk(irq_n, !(eaf && n[3]));
    end
    $display("alarm test done");
    @(posedge clk);
    alarm_irq_enable <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wreg(8'h11, 8'(i * 8 + 6));
      wreg(8'h10, 8'h02);
      wait_cf(i, j);
      clrf();
      wait_cf(i, j);
      chk(8'(j), 8'h02);
      chk(irq_n, 1'b0);
      clrf();
    end
    wreg(8'h11, 8'h07);
    wait_cf(0, j);
    for (n = 0; n < 20 && irq_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({irq_n, cf}, 2'b11);
    wreg(8'h11, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk({irq_n, cf}, 2'b11);
    wreg(8'h10, 8'h00);
    clrf();
    repeat (200) @(posedge clk);
    #1;
    chk(cf, 1'b0);
    rreg(8'h10, 8'h00);
    $display("countdown test done");
    final_report();
  end
endmodule : tb_top

// ---- tb/tick_gen.sv ----
// divider chain model: one-cycle source ticks at scaled-down rates
module tick_gen (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  output logic      [3:0] tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_r;
  // rates keep their order, each source slower than the one before
  always @(posedge sys_clk_i) begin
    cnt_r <= reset_i ? 6'h00 : cnt_r + 6'h01;
    tick_o[0] <= !reset_i && cnt_r[2:0] == 3'h7;
    tick_o[1] <= !reset_i && cnt_r[3:0] == 4'hf;
    tick_o[2] <= !reset_i && cnt_r[4:0] == 5'h1f;
    tick_o[3] <= !reset_i && cnt_r == 6'h3f;
  end
endmodule : tick_gen
